// ===== core/sbm_master.sv
// system bus master with register port
// Overview of operation
// - bus reset is active low and forces the bus into a safe state
// - in reset the default master drives address-only and lock low
// - in reset non-default masters and slaves float their shared outputs
// - after release the default master may announce a transfer at once
// - all bus timing follows one bus clock using both edges
// - shared lines keep their last level while undriven
// - transfer type: 00 address-only, 10 nonsequential, 11 sequential
// - sequential addresses follow the previous; nonsequential are free
// - transfer type upper bit means data transfer next cycle
// - transfer type is driven in the high phase while granted
// - the master supplies a 32-bit memory-mapped address
// - direction low for read, high for write
// - size: 00 byte, 01 halfword, 10 word, 11 reserved
// - narrow writes replicate data; reads use the slave's lane
// - protection: bit0 fetch/data, bit1 user/privileged
// - a new owner starts with address-only for turnaround
`default_nettype none
module sbm_master
  import sbm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // arbitration and response
  input  wire logic        bus_reset_n,
  input  wire logic        master_grant,
  input  wire logic        wait_resp,
  output logic             bus_clk,
  // shared transfer lines
  output logic [1:0]       xfer_type,
  output logic             xfer_type_oe,
  output logic             bus_lock,
  output logic             bus_lock_oe,
  output logic [31:0]      bus_addr,
  output logic             xfer_dir,
  output logic [1:0]       xfer_size,
  output logic [1:0]       xfer_prot,
  output logic             addr_ctl_oe,
  // shared data lines
  input  wire logic [31:0] bus_data_in,
  output logic [31:0]      bus_data_out,
  output logic             bus_data_oe
);
  import sbm_pkg::*;

  sbm_phase_if pif ();

  sbm_phase_keep u_phase (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .bus_data_in (bus_data_in),
    .pif         (pif)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] size_step(input logic [1:0] sz);
    return (sz == XS_BYTE) ? 32'h1 : (sz == XS_HALF) ? 32'h2 : 32'h4;
  endfunction

  // register group
  logic [11:0] ctrl_reg;
  logic [11:0] ctrl_next;
  logic [31:0] start_addr_reg;
  logic [31:0] start_addr_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic [4:0]  cmd_reg;
  logic [4:0]  cmd_next;
  logic        start_reg;
  logic        start_next;
  logic        done_flag_reg;
  logic        done_flag_next;
  logic        bad_flag_reg;
  logic        bad_flag_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // engine group
  sbm_own_t    own_reg;
  sbm_own_t    own_next;
  logic [1:0]  type_reg;
  logic [1:0]  type_next;
  logic        type_oe_reg;
  logic        type_oe_next;
  logic        lock_reg;
  logic        lock_next;
  logic        lock_oe_reg;
  logic        lock_oe_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic        dir_reg;
  logic        dir_next;
  logic [1:0]  size_reg;
  logic [1:0]  size_next;
  logic [1:0]  prot_reg;
  logic [1:0]  prot_next;
  logic        actl_oe_reg;
  logic        actl_oe_next;
  logic [31:0] dout_reg;
  logic [31:0] dout_next;
  logic        doe_reg;
  logic        doe_next;
  logic        active_reg;
  logic        active_next;
  logic        first_reg;
  logic        first_next;
  logic [4:0]  ann_left_reg;
  logic [4:0]  ann_left_next;
  logic [4:0]  cmp_left_reg;
  logic [4:0]  cmp_left_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        done_evt;
  logic        in_rst_reg;

  logic        bus_rst;
  logic        busy;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] status_word;

  // reset pin is sampled on mclk, so assertion acts at the next edge
  assign bus_rst     = ~bus_reset_n;
  assign busy        = start_reg | (cmp_left_reg != 5'h0);
  assign wb_req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_wr       = wb_req & wb_we_i;
  assign pif.keep_en = active_reg & ~dir_reg;
  assign status_word = {27'h0, bad_flag_reg, done_flag_reg, in_rst_reg,
                        own_reg != OWN_IDLE, busy};

  always_comb
  begin
    ctrl_next       = ctrl_reg;
    start_addr_next = start_addr_reg;
    wdata_next      = wdata_reg;
    cmd_next        = cmd_reg;
    start_next      = 1'b0;
    done_flag_next  = done_flag_reg;
    bad_flag_next   = bad_flag_reg;
    ack_next        = wb_req;
    rd_next         = rd_reg;
    if (wb_wr)
    begin
      unique case (wb_adr_i)
        REG_CTRL:
        begin
          ctrl_next = 12'(merge({20'h0, ctrl_reg}, wb_dat_i, wb_sel_i));
          ctrl_next[CTRL_GO] = 1'b0;
          // the reserved size is refused at go; a command write during a burst can still put it on the bus
          if (wb_sel_i[0] && wb_dat_i[CTRL_GO])
          begin
            if (busy || cmd_reg[CMD_SIZE_H:CMD_SIZE_L] == XS_RSVD)
              bad_flag_next = 1'b1;
            else
              start_next = 1'b1;
          end
        end
        REG_ADDR:   start_addr_next = merge(start_addr_reg, wb_dat_i, wb_sel_i);
        REG_WDATA:  wdata_next = merge(wdata_reg, wb_dat_i, wb_sel_i);
        REG_CMD:    cmd_next = 5'(merge({27'h0, cmd_reg}, wb_dat_i, wb_sel_i));
        REG_STATUS:
        begin
          if (wb_sel_i[0] && wb_dat_i[ST_DONE])
            done_flag_next = 1'b0;
          if (wb_sel_i[0] && wb_dat_i[ST_BAD])
            bad_flag_next = 1'b0;
        end
        default: ;
      endcase
    end
    if (done_evt)
      done_flag_next = 1'b1;
    if (wb_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        REG_CTRL:   rd_next = {20'h0, ctrl_reg};
        REG_ADDR:   rd_next = start_addr_reg;
        REG_WDATA:  rd_next = wdata_reg;
        REG_CMD:    rd_next = {27'h0, cmd_reg};
        REG_RDATA:  rd_next = rdata_reg;
        REG_STATUS: rd_next = status_word;
        default:    rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_reg       <= CTRL_RST;
      start_addr_reg <= 32'h0;
      wdata_reg      <= 32'h0;
      cmd_reg        <= CMD_RST;
      start_reg      <= 1'b0;
      done_flag_reg  <= 1'b0;
      bad_flag_reg   <= 1'b0;
      ack_reg        <= 1'b0;
      rd_reg         <= 32'h0;
    end
    else
    begin
      ctrl_reg       <= ctrl_next;
      start_addr_reg <= start_addr_next;
      wdata_reg      <= wdata_next;
      cmd_reg        <= cmd_next;
      start_reg      <= start_next;
      done_flag_reg  <= done_flag_next;
      bad_flag_reg   <= bad_flag_next;
      ack_reg        <= ack_next;
      rd_reg         <= rd_next;
    end
  end

  always_comb
  begin
    own_next      = own_reg;
    type_next     = type_reg;
    type_oe_next  = type_oe_reg;
    lock_next     = lock_reg;
    lock_oe_next  = lock_oe_reg;
    addr_next     = addr_reg;
    dir_next      = dir_reg;
    size_next     = size_reg;
    prot_next     = prot_reg;
    actl_oe_next  = actl_oe_reg;
    dout_next     = dout_reg;
    doe_next      = doe_reg;
    active_next   = active_reg;
    first_next    = first_reg;
    ann_left_next = ann_left_reg;
    cmp_left_next = cmp_left_reg;
    rdata_next    = rdata_reg;
    done_evt      = 1'b0;
    if (start_reg)
    begin
      ann_left_next = 5'(ctrl_reg[CTRL_BEAT_H:CTRL_BEAT_L]) + 5'h1;
      cmp_left_next = 5'(ctrl_reg[CTRL_BEAT_H:CTRL_BEAT_L]) + 5'h1;
      first_next    = 1'b1;
    end
    if (bus_rst)
    begin
      // the default master parks the bus; any other master floats
      own_next      = ctrl_reg[CTRL_DFLT] ? OWN_ACT : OWN_IDLE;
      type_next     = XT_ADDR_ONLY;
      type_oe_next  = ctrl_reg[CTRL_DFLT];
      lock_next     = 1'b0;
      lock_oe_next  = ctrl_reg[CTRL_DFLT];
      actl_oe_next  = 1'b0;
      doe_next      = 1'b0;
      active_next   = 1'b0;
      ann_left_next = 5'h0;
      cmp_left_next = 5'h0;
    end
    else if (pif.rise)
    begin
      // wait low closes the cycle; only then does grant change ownership
      if (!wait_resp)
      begin
        unique case (own_reg)
          OWN_IDLE: own_next = master_grant ? OWN_TURN : OWN_IDLE;
          OWN_TURN: own_next = master_grant ? OWN_ACT : OWN_IDLE;
          OWN_ACT:  own_next = master_grant ? OWN_ACT : OWN_IDLE;
        endcase
        if (active_reg)
        begin
          // reads take the lane the slave drove, no lane steering
          if (!dir_reg)
            rdata_next = pif.kept;
          cmp_left_next = cmp_left_reg - 5'h1;
          done_evt      = (cmp_left_reg == 5'h1);
        end
        // an announced data type opens the transfer in the cycle after the announce
        active_next = type_reg[XT_DATA_BIT] & (own_reg == OWN_ACT);
        type_next   = XT_ADDR_ONLY;
        // a fresh owner spends its first cycle address-only
        if (own_next == OWN_ACT && own_reg == OWN_ACT && ann_left_next != 5'h0)
        begin
          // reserved codes are unreachable: only three types exist
          type_next     = first_next ? XT_NSEQ : XT_SEQ;
          ann_left_next = ann_left_next - 5'h1;
          // a burst steps from the last address by the beat size
          addr_next = first_next ? start_addr_reg : addr_reg + size_step(size_reg);
          // cleared after the address pick, else the first beat would step too
          first_next    = 1'b0;
          dir_next  = cmd_reg[CMD_DIR];
          size_next = cmd_reg[CMD_SIZE_H:CMD_SIZE_L];
          prot_next = cmd_reg[CMD_PROT_H:CMD_PROT_L];
        end
        else if (own_next != OWN_ACT)
        begin
          // losing the bus abandons unannounced beats
          ann_left_next = 5'h0;
          cmp_left_next = active_reg ? cmp_left_next : 5'h0;
        end
      end
      // type lines are driven in the high phase while granted
      type_oe_next = master_grant;
      lock_oe_next = master_grant;
      lock_next    = ctrl_reg[CTRL_LOCK] & (ann_left_next != 5'h0);
      // stop driving in the high phase once ownership is lost
      actl_oe_next = (own_next == OWN_ACT);
      doe_next     = 1'b0;
    end
    else if (pif.fall)
    begin
      type_oe_next = 1'b0;
      // the turnaround cycle starts driving address in its low phase
      actl_oe_next = (own_reg != OWN_IDLE);
      // narrow writes put the data on every lane
      unique case (size_reg)
        XS_BYTE: dout_next = {4{wdata_reg[7:0]}};
        XS_HALF: dout_next = {2{wdata_reg[15:0]}};
        default: dout_next = wdata_reg;
      endcase
      doe_next = active_reg & dir_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      own_reg      <= OWN_IDLE;
      type_reg     <= XT_ADDR_ONLY;
      type_oe_reg  <= 1'b0;
      lock_reg     <= 1'b0;
      lock_oe_reg  <= 1'b0;
      addr_reg     <= 32'h0;
      dir_reg      <= 1'b0;
      size_reg     <= XS_WORD;
      prot_reg     <= 2'h0;
      actl_oe_reg  <= 1'b0;
      dout_reg     <= 32'h0;
      doe_reg      <= 1'b0;
      active_reg   <= 1'b0;
      first_reg    <= 1'b1;
      ann_left_reg <= 5'h0;
      cmp_left_reg <= 5'h0;
      rdata_reg    <= 32'h0;
      in_rst_reg   <= 1'b0;
    end
    else
    begin
      own_reg      <= own_next;
      type_reg     <= type_next;
      type_oe_reg  <= type_oe_next;
      lock_reg     <= lock_next;
      lock_oe_reg  <= lock_oe_next;
      addr_reg     <= addr_next;
      dir_reg      <= dir_next;
      size_reg     <= size_next;
      prot_reg     <= prot_next;
      actl_oe_reg  <= actl_oe_next;
      dout_reg     <= dout_next;
      doe_reg      <= doe_next;
      active_reg   <= active_next;
      first_reg    <= first_next;
      ann_left_reg <= ann_left_next;
      cmp_left_reg <= cmp_left_next;
      rdata_reg    <= rdata_next;
      in_rst_reg   <= bus_rst;
    end
  end

  // all outputs come from flip-flops
  assign wb_dat_o     = rd_reg;
  assign wb_ack_o     = ack_reg;
  assign bus_clk      = pif.bclk;
  assign xfer_type    = type_reg;
  assign xfer_type_oe = type_oe_reg;
  assign bus_lock     = lock_reg;
  assign bus_lock_oe  = lock_oe_reg;
  assign bus_addr     = addr_reg;
  assign xfer_dir     = dir_reg;
  assign xfer_size    = size_reg;
  assign xfer_prot    = prot_reg;
  assign addr_ctl_oe  = actl_oe_reg;
  assign bus_data_out = dout_reg;
  assign bus_data_oe  = doe_reg;
endmodule
`default_nettype wire

// ===== pkg/sbm_pkg.sv
// constants, codes and register map of the system bus master
`default_nettype none
package sbm_pkg;
  // clocking
  localparam int unsigned MCLK_HZ   = 20_000_000;
  localparam int unsigned BCLK_HZ   = 10_000_000;
  localparam int unsigned PHASE_CYC = MCLK_HZ / (2 * BCLK_HZ);
  localparam logic [3:0]  PHASE_MAX = 4'(PHASE_CYC - 1);

  // transfer type codes; 2'b01 is reserved and never generated
  localparam logic [1:0] XT_ADDR_ONLY = 2'h0;
  localparam logic [1:0] XT_NSEQ      = 2'h2;
  localparam logic [1:0] XT_SEQ       = 2'h3;
  localparam int unsigned XT_DATA_BIT = 1;

  // transfer size codes; 2'b11 is reserved
  localparam logic [1:0] XS_BYTE  = 2'h0;
  localparam logic [1:0] XS_HALF  = 2'h1;
  localparam logic [1:0] XS_WORD  = 2'h2;
  localparam logic [1:0] XS_RSVD  = 2'h3;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // control fields
  localparam int unsigned CTRL_DFLT   = 0;
  localparam int unsigned CTRL_LOCK   = 1;
  localparam int unsigned CTRL_GO     = 2;
  localparam int unsigned CTRL_BEAT_L = 8;
  localparam int unsigned CTRL_BEAT_H = 11;
  localparam logic [11:0] CTRL_RST    = 12'h001;

  // command fields
  localparam int unsigned CMD_DIR    = 0;
  localparam int unsigned CMD_SIZE_L = 1;
  localparam int unsigned CMD_SIZE_H = 2;
  localparam int unsigned CMD_PROT_L = 3;
  localparam int unsigned CMD_PROT_H = 4;
  localparam logic [4:0]  CMD_RST    = 5'h04;

  // status fields
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_OWNER = 1;
  localparam int unsigned ST_INRST = 2;
  localparam int unsigned ST_DONE  = 3;
  localparam int unsigned ST_BAD   = 4;

  // bus ownership states
  typedef enum logic [2:0] {
    OWN_IDLE = 3'b001,
    OWN_TURN = 3'b010,
    OWN_ACT  = 3'b100
  } sbm_own_t;
endpackage
`default_nettype wire

// ===== pkg/sbm_phase_if.sv
// bus clock phase events and data keeper hand-off
`default_nettype none
interface sbm_phase_if;
  logic        bclk;
  logic        rise;
  logic        fall;
  logic        keep_en;
  logic [31:0] kept;
  modport src (output bclk, output rise, output fall, output kept, input keep_en);
  modport snk (input bclk, input rise, input fall, input kept, output keep_en);
endinterface
`default_nettype wire

// ===== core/sbm_phase_keep.sv
// bus clock phase divider and data line keeper
`default_nettype none
module sbm_phase_keep
  import sbm_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // sampled shared data lines
  input  wire logic [31:0] bus_data_in,
  // phase events and kept data
  sbm_phase_if.src         pif
);
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic        bclk_reg;
  logic        bclk_next;
  logic [31:0] kept_reg;
  logic [31:0] kept_next;
  logic        term;

  assign term     = (cnt_reg == PHASE_MAX);
  // one mclk per phase: both bus clock edges become enable pulses
  assign pif.rise = term & ~bclk_reg;
  assign pif.fall = term & bclk_reg;
  assign pif.bclk = bclk_reg;
  // live lanes while reading: the slave's data only stands in the low phase
  assign pif.kept = kept_next;

  always_comb
  begin
    cnt_next  = term ? 4'h0 : cnt_reg + 4'h1;
    bclk_next = term ? ~bclk_reg : bclk_reg;
  end

  // each lane follows the data lines while a read is active and holds its last sampled level otherwise
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      always_comb
      begin
        kept_next[g*8 +: 8] = pif.keep_en ? bus_data_in[g*8 +: 8] : kept_reg[g*8 +: 8];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cnt_reg  <= 4'h0;
      bclk_reg <= 1'b0;
      kept_reg <= 32'h0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      bclk_reg <= bclk_next;
      kept_reg <= kept_next;
    end
  end
endmodule
`default_nettype wire

// ===== sim/sbm_chk.sv
// port-level assertions for the system bus master
`default_nettype none
module sbm_chk
  import sbm_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       sys_rst,
  // bus lines
  input wire logic       bus_reset_n,
  input wire logic       master_grant,
  input wire logic       wait_resp,
  input wire logic       bus_clk,
  input wire logic [1:0] xfer_type,
  input wire logic       xfer_type_oe,
  input wire logic       bus_lock,
  input wire logic       xfer_dir,
  input wire logic [1:0] xfer_size,
  input wire logic       addr_ctl_oe,
  input wire logic       bus_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // three samples absorb the one-cycle sampling of the bus reset
  a_rst_safe: assert property (
    (!bus_reset_n)[*3] |-> xfer_type == XT_ADDR_ONLY && !bus_lock && !addr_ctl_oe
      && !bus_data_oe)
    else $error("bus outputs unsafe during bus reset");
  a_type_legal: assert property (
    xfer_type_oe |-> xfer_type != 2'h1)
    else $error("reserved transfer type driven");
  a_size_legal: assert property (
    addr_ctl_oe |-> xfer_size != XS_RSVD)
    else $error("reserved transfer size driven");
  // in bus reset the default master parks the type lines in both phases
  a_type_phase: assert property (
    bus_reset_n && $past(bus_reset_n) && xfer_type_oe |-> bus_clk)
    else $error("transfer type driven outside high phase");
  a_type_grant: assert property (
    !bus_clk && !master_grant && bus_reset_n && $past(bus_reset_n) |=> !xfer_type_oe)
    else $error("transfer type driven without grant");
  a_bclk_toggle: assert property (
    !$past(sys_rst) |-> bus_clk != $past(bus_clk))
    else $error("bus clock missed a phase");
  a_wdata_phase: assert property (
    bus_data_oe |-> xfer_dir && !bus_clk)
    else $error("data driven outside a write low phase");
  a_data_next: assert property (
    xfer_type_oe && xfer_type[XT_DATA_BIT] && xfer_dir ##1 !wait_resp |=> ##1 bus_data_oe)
    else $error("write data missing after announce");
endmodule

bind sbm_master sbm_chk sbm_chk_i (
  .mclk, .sys_rst, .bus_reset_n, .master_grant, .wait_resp, .bus_clk, .xfer_type,
  .xfer_type_oe, .bus_lock, .xfer_dir, .xfer_size, .addr_ctl_oe, .bus_data_oe
);
`default_nettype wire

// ===== sim/sbm_far_model.sv
// arbiter and slave stand-in on the far side of the master
`default_nettype none
module sbm_far_model (
  // clock and master lines
  input  wire logic        mclk,
  input  wire logic        bus_clk,
  input  wire logic        bus_reset_n,
  input  wire logic [1:0]  xfer_type,
  input  wire logic        xfer_type_oe,
  input  wire logic        xfer_dir,
  input  wire logic        addr_ctl_oe,
  input  wire logic [31:0] bus_data_out,
  input  wire logic        bus_data_oe,
  // scenario controls; protection lines are ignored here
  input  wire logic        grant_en,
  input  wire logic [2:0]  nwait,
  input  wire logic [31:0] rdata,
  // responses
  output logic             master_grant,
  output logic             wait_resp,
  output logic [31:0]      bus_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0]  cnt_reg;
  logic        pend_reg;
  logic [31:0] kept_reg;
  logic        ann;
  logic        slv_drv;
  assign ann = xfer_type_oe && xfer_type[1];
  assign master_grant = !bus_reset_n || grant_en;
  assign wait_resp = cnt_reg != 3'h0;
  assign slv_drv = bus_reset_n && addr_ctl_oe && !xfer_dir && !bus_clk;
  // undriven lanes hold their last level, as a keeper would
  assign bus_data_in = bus_data_oe ? bus_data_out : (slv_drv ? rdata : kept_reg);
  always_ff @(posedge mclk)
  begin
    kept_reg <= bus_data_in;
    if (!bus_reset_n)
    begin
      cnt_reg  <= 3'h0;
      pend_reg <= 1'b0;
    end
    else if (bus_clk)
    begin
      if (cnt_reg != 3'h0)
        cnt_reg <= cnt_reg - 3'h1;
      else if (pend_reg)
        cnt_reg <= nwait;
      pend_reg <= (cnt_reg == 3'h0) ? ann : (pend_reg || ann);
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the system bus master
`default_nettype none
module tb
  import sbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        bus_reset_n = 1'b1;
  logic        grant_en = 1'b1;
  logic [2:0]  nwait = 3'h0;
  logic [31:0] rdata = 32'h0;
  logic [31:0] wb_dat_o, bus_addr, bus_data_in, bus_data_out, last_wd, lat_a;
  logic [1:0]  xfer_type, xfer_size, xfer_prot;
  logic        wb_ack_o, master_grant, wait_resp, bus_clk, xfer_type_oe, bus_lock;
  logic        bus_lock_oe, xfer_dir, addr_ctl_oe, bus_data_oe;
  logic        lat_v = 1'b0;
  logic        dflt_v = 1'b1;
  logic        lock_v = 1'b0;
  logic [6:0]  lat_c;
  int          oe_cnt = 0;
  int          err_count = 0;
  int          num_checks = 0;
  logic [31:0] qa[$];
  logic [6:0]  qc[$];

  sbm_master sbm_master_i (
    .mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .bus_reset_n, .master_grant, .wait_resp, .bus_clk, .xfer_type,
    .xfer_type_oe, .bus_lock, .bus_lock_oe, .bus_addr, .xfer_dir, .xfer_size, .xfer_prot,
    .addr_ctl_oe, .bus_data_in, .bus_data_out, .bus_data_oe
  );
  sbm_far_model sbm_far_model_i (
    .mclk, .bus_clk, .bus_reset_n, .xfer_type, .xfer_type_oe, .xfer_dir, .addr_ctl_oe,
    .bus_data_out, .bus_data_oe, .grant_en, .nwait, .rdata, .master_grant, .wait_resp,
    .bus_data_in
  );

  always #25 mclk = ~mclk;

  // an announce counts once, at the rise where the bus accepts it
  always @(posedge mclk)
  begin
    if (bus_clk === 1'b1 && xfer_type_oe === 1'b1 && xfer_type[1] === 1'b1)
    begin
      lat_v <= 1'b1;
      lat_a <= bus_addr;
      lat_c <= {xfer_type, xfer_dir, xfer_size, xfer_prot};
    end
    else if (bus_clk === 1'b0 && lat_v && wait_resp === 1'b0)
    begin
      qa.push_back(lat_a);
      qc.push_back(lat_c);
      lat_v <= 1'b0;
    end
    if (bus_data_oe === 1'b1)
      last_wd <= bus_data_out;
    if (xfer_type_oe === 1'b1)
      oe_cnt <= oe_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge mclk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [31:0] rep(input logic [1:0] sz, input logic [31:0] d);
    if (sz == XS_BYTE)
      return {4{d[7:0]}};
    if (sz == XS_HALF)
      return {2{d[15:0]}};
    return d;
  endfunction

  task automatic xfer(input logic dir, input logic [1:0] sz, input logic [1:0] pr,
                      input logic [3:0] nb, input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] q;
    int          eb;
    eb = (sz == XS_RSVD) ? 0 : int'(nb);
    qa.delete();
    qc.delete();
    wb(1'b1, REG_ADDR, a, q);
    wb(1'b1, REG_WDATA, wd, q);
    wb(1'b1, REG_CMD, {27'h0, pr, sz, dir}, q);
    wb(1'b1, REG_CTRL, {20'h0, nb - 4'h1, 5'h0, 1'b1, lock_v, dflt_v}, q);
    q = 32'h0;
    while (q[ST_DONE] !== 1'b1 && q[ST_BAD] !== 1'b1)
      wb(1'b0, REG_STATUS, 32'h0, q);
    chk("bad", 32'(sz == XS_RSVD), 32'(q[ST_BAD]));
    wb(1'b1, REG_STATUS, 32'h18, q);
    chk("beats", 32'(eb), 32'(qa.size()));
    for (int i = 0; i < eb; i++)
    begin
      chk("addr", a + (32'(i) << sz), qa[i]);
      chk("ctl", {25'h0, (i == 0) ? XT_NSEQ : XT_SEQ, dir, sz, pr}, {25'h0, qc[i]});
    end
    if (eb != 0 && dir)
      chk("wdata", rep(sz, wd), last_wd);
    if (eb != 0 && !dir)
    begin
      wb(1'b0, REG_RDATA, 32'h0, q);
      chk("rdata", rdata, q);
    end
  endtask

  task automatic brst(input logic dflt);
    logic [31:0] q;
    @(posedge mclk);
    bus_reset_n <= 1'b0;
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("in_reset", 32'h1, 32'(q[ST_INRST]));
    do
      @(negedge mclk);
    while (bus_clk !== 1'b1);
    chk("bus_safe", {25'h0, 2'h0, 1'b0, dflt, dflt, 2'h0}, {25'h0, xfer_type, bus_lock,
        xfer_type_oe, bus_lock_oe, addr_ctl_oe, bus_data_oe});
    @(posedge mclk);
    bus_reset_n <= 1'b1;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    logic [31:0] q;
    int          n0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl_rst", 32'(CTRL_RST), q);
    wb(1'b0, REG_CMD, 32'h0, q);
    chk("cmd_rst", 32'(CMD_RST), q);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("unmapped", 32'h0, q);
    brst(1'b1);
    xfer(1'b1, XS_WORD, 2'h3, 4'h1, 32'h8000_0010, 32'hCAFE_F00D);
    for (int k = 0; k < 4; k++)
      xfer(k[0], 2'(k % 3), 2'(k), 4'h1, 32'h2000_0100 + 32'(k << 4), 32'h1122_33A4);
    lock_v = 1'b1;
    nwait <= 3'h2;
    rdata <= 32'h5A5A_0FF1;
    xfer(1'b0, XS_WORD, 2'h1, 4'h4, 32'h1000_00F0, 32'h0);
    lock_v = 1'b0;
    nwait <= 3'h0;
    xfer(1'b1, XS_RSVD, 2'h0, 4'h1, 32'h3000_0000, 32'h0);
    dflt_v = 1'b0;
    grant_en <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h0, q);
    brst(1'b0);
    n0 = oe_cnt;
    repeat (20) @(posedge mclk);
    chk("no_grant_oe", 32'(n0), 32'(oe_cnt));
    grant_en <= 1'b1;
    xfer(1'b1, XS_HALF, 2'h2, 4'h2, 32'h4000_0000, 32'h0000_BEEF);
    tally_and_finish();
  end

  // the whole sequence needs a few hundred cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
